// [clid_core.sv]
`timescale 1ns/100ps
module clid_core
    import clid_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source pins, bit i is source i, active high levels
    input wire logic [7:0] src_irq,
    // Agent chip number strap
    input wire logic [2:0] agent_chip_select,
    // Control/status register port
    input wire logic csr_wr_en,
    input wire logic csr_rd_en,
    input wire logic [clid_pkg::SEL_W-1:0] csr_sel,
    input wire logic [clid_pkg::DW-1:0] csr_wdata,
    output logic [clid_pkg::DW-1:0] csr_rdata,
    output logic csr_rvalid,
    // Stores from processors to a local request register
    input wire logic cpu_st_valid,
    input wire logic cpu_st_dw,
    input wire logic [1:0] cpu_st_pos,
    input wire logic [clid_pkg::DW-1:0] cpu_st_data,
    // Pending clear from the processors' own handlers
    input wire logic cpu_clr_valid,
    input wire logic [1:0] cpu_clr_pos,
    input wire logic [clid_pkg::DW-1:0] cpu_clr_bits,
    // Processor interrupt state
    input wire logic [3:0] cpu_psw_ien,
    input wire logic [3:0][clid_pkg::DW-1:0] ext_intr_enable_mask,
    output logic [3:0] cpu_intr,
    output logic [3:0][clid_pkg::DW-1:0] ext_intr_request_reg,
    // Non-interrupt exceptions, one pulse per delivery
    output logic [3:0] cpu_exc_valid,
    output logic [1:0] cpu_exc_type,
    // Delivery write trace
    output logic dlv_valid,
    output logic [4:0] dlv_cpu_id,
    output logic [1:0] dlv_type,
    output logic [5:0] dlv_num
);
    import clid_pkg::*;

    // Delivery engine states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WALK = 1'b1
    } clid_st_e;

    // All state of the agent chip side
    typedef struct packed {
        logic [7:0] src_s1;
        logic [7:0] src_s2;
        logic [2:0] chip_s1;
        logic [2:0] chip_s2;
        logic [DW-1:0] dlv_lo;
        logic [DW-1:0] dlv_hi;
        logic [3:0][DW-1:0] pend;
        logic [7:0] sent_prev;
        logic [7:0] work;
        clid_st_e st;
        logic [2:0] src;
        logic [1:0] cpu;
        logic [3:0] intr;
        logic [3:0] exc_valid;
        logic [1:0] exc_type;
        logic dlv_valid;
        logic [4:0] dlv_id;
        logic [1:0] dlv_type;
        logic [5:0] dlv_num;
        logic [DW-1:0] rdata;
        logic rvalid;
    } clid_core_s;

    clid_core_s q;
    clid_core_s d;

    // Utilities controller wires
    logic [7:0] u_status; // Latched status bits
    logic [7:0] u_mask; // Mask register
    logic [7:0] u_force; // Force register
    logic [7:0] u_sent; // Masked set plus forced bits on the core logic bus
    logic u_wr_en; // Write to a utilities register
    logic [7:0] u_wr_bits; // Source bits of the write, in order

    // Only the three utilities selectors reach the controller
    assign u_wr_en = csr_wr_en && (csr_sel == SEL_STATUS ||
        csr_sel == SEL_MASK || csr_sel == SEL_FORCE);
    // Big-endian field bits 0:7 become sources 0..7
    assign u_wr_bits = clid_rev8(csr_wdata[SRC_FLD_LSB +: NSRC]); // see R07

    // Utilities board interrupt controller
    clid_util_ctrl u_util (
        .clk(clk),
        .rst_n(rst_n),
        .src_lvl(q.src_s2),
        .wr_en(u_wr_en),
        .wr_sel(csr_sel),
        .wr_bits(u_wr_bits),
        .status(u_status),
        .mask(u_mask),
        .force_bits(u_force),
        .sent(u_sent)
    );

    // Combinational helpers for the engine
    logic [ENT_W-1:0] ent; // Entry of the source being walked
    logic [3:0] ent_en; // Processor enables of that entry
    logic [1:0] ent_type; // Exception type of that entry
    logic [5:0] ent_num; // Interrupt number of that entry
    logic [1:0] ent_pos; // Position field of the walked processor

    always_comb begin
        ent = clid_entry(q.dlv_lo, q.dlv_hi, q.src); // see R18
        ent_en = ent[ENT_EN_LSB +: NCPU]; // see R21
        ent_type = ent[ENT_TYPE_LSB +: 2]; // see R21
        ent_num = ent[ENT_NUM_LSB +: IRQ_NUM_W]; // see R21
        ent_pos = q.cpu;
    end

    // Next state of the whole agent chip side
    always_comb begin
        d = q;
        // Pins pass two flops before any logic looks at them
        d.src_s1 = src_irq;
        d.src_s2 = q.src_s1;
        d.chip_s1 = agent_chip_select;
        d.chip_s2 = q.chip_s1;

        // Delivery registers, full-width register writes
        if (csr_wr_en && csr_sel == SEL_DLV_LO) begin
            d.dlv_lo = csr_wdata; // see R17 see R20
        end
        if (csr_wr_en && csr_sel == SEL_DLV_HI) begin
            d.dlv_hi = csr_wdata; // see R17 see R20
        end

        // Register reads answer one cycle later
        d.rvalid = csr_rd_en;
        d.rdata = '0;
        if (csr_rd_en) begin
            if (csr_sel == SEL_DLV_LO) begin
                d.rdata = q.dlv_lo; // see R20
            end else if (csr_sel == SEL_DLV_HI) begin
                d.rdata = q.dlv_hi; // see R20
            end else if (csr_sel == SEL_STATUS) begin
                d.rdata[SRC_FLD_LSB +: NSRC] = clid_rev8(u_status); // see R08
            end else if (csr_sel == SEL_MASK) begin
                d.rdata[SRC_FLD_LSB +: NSRC] = clid_rev8(u_mask);
            end else if (csr_sel == SEL_FORCE) begin
                d.rdata[SRC_FLD_LSB +: NSRC] = clid_rev8(u_force); // see R13
            end else begin
                d.rdata = '0;
            end
        end

        // A source that rises on the bus starts one delivery round;
        // a bit cleared and set again rises again and is re-sent
        d.sent_prev = u_sent; // see R14

        // Pulses last one cycle
        d.dlv_valid = 1'b0;
        d.exc_valid = 4'h0;

        // Handler clears go first, so a store or delivery set still wins
        if (cpu_clr_valid) begin
            d.pend[cpu_clr_pos] = d.pend[cpu_clr_pos] & ~cpu_clr_bits;
        end
        // Processor stores: only doublewords reach the register
        if (cpu_st_valid && cpu_st_dw) begin
            d.pend[cpu_st_pos][cpu_st_data[IRQ_NUM_LSB +: IRQ_NUM_W]] =
                1'b1; // see R01 see R02
        end

        // Delivery engine, one processor per cycle
        case (q.st)
            ST_IDLE: begin
                // Lowest numbered waiting source goes first
                for (int i = NSRC - 1; i >= 0; i--) begin
                    if (q.work[i]) begin
                        d.src = 3'(i);
                    end
                end
                d.cpu = 2'h0;
                if (q.work != 8'h00) begin
                    d.st = ST_WALK;
                end
            end
            ST_WALK: begin
                if (ent_en[q.cpu]) begin // see R15
                    // Writes go out one at a time
                    d.dlv_valid = 1'b1; // see R16 see R22
                    d.dlv_id = clid_cpu_id(q.chip_s2, ent_pos); // see R04
                    d.dlv_type = ent_type; // see R19
                    d.dlv_num = ent_num; // see R16
                    if (ent_type == CLID_EXC_INTR) begin
                        d.pend[q.cpu][ent_num] = 1'b1; // see R02 see R16
                    end else begin
                        d.exc_valid[q.cpu] = 1'b1; // see R19
                        d.exc_type = ent_type; // see R19
                    end
                end
                d.cpu = q.cpu + 2'h1;
                if (q.cpu == 2'(NCPU - 1)) begin
                    d.work[q.src] = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Queue rising sources after the engine's own clear, so a rise
        // in the last walk cycle of the same source is not lost
        d.work = d.work | (u_sent & ~q.sent_prev); // see R11 see R14

        // Processor interrupt line needs both enables
        for (int p = 0; p < NCPU; p++) begin
            d.intr[p] = cpu_psw_ien[p] &&
                ((q.pend[p] & ext_intr_enable_mask[p]) != '0); // see R03
        end

        // Reset clears control state but keeps delivery contents
        if (!rst_n) begin
            d = '0;
            d.dlv_lo = q.dlv_lo; // see R20
            d.dlv_hi = q.dlv_hi; // see R20
            d.st = ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        q <= d;
    end

    // Outputs come straight from the state flops
    assign csr_rdata = q.rdata;
    assign csr_rvalid = q.rvalid;
    assign cpu_intr = q.intr;
    assign ext_intr_request_reg = q.pend;
    assign cpu_exc_valid = q.exc_valid;
    assign cpu_exc_type = q.exc_type;
    assign dlv_valid = q.dlv_valid;
    // Processor numbering follows position and chip, see R05 see R06
    assign dlv_cpu_id = q.dlv_id;
    assign dlv_type = q.dlv_type;
    assign dlv_num = q.dlv_num;

endmodule

// [clid_core_assertions.sv]
`timescale 1ns/100ps
module clid_core_assertions
    import clid_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic csr_rd_en,
    input wire logic [2:0] csr_sel,
    input wire logic [63:0] csr_rdata,
    input wire logic csr_rvalid,
    // Processor side
    input wire logic cpu_st_valid,
    input wire logic cpu_st_dw,
    input wire logic [1:0] cpu_st_pos,
    input wire logic [63:0] cpu_st_data,
    input wire logic [3:0] cpu_psw_ien,
    input wire logic [3:0] cpu_intr,
    input wire logic [3:0][63:0] ext_intr_request_reg,
    // Delivery trace
    input wire logic [2:0] agent_chip_select,
    input wire logic dlv_valid,
    input wire logic [4:0] dlv_cpu_id,
    input wire logic [1:0] dlv_type,
    input wire logic [5:0] dlv_num
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_ans;
        csr_rd_en |=> csr_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read got no answer");
    property p_rd_only;
        !csr_rd_en |=> !csr_rvalid;
    endproperty
    a_rd_only: assert property (p_rd_only)
        else $error("answer without read");
    // Unknown selectors must read as zero, never stale data
    property p_rd_void;
        csr_rd_en && csr_sel > 3'h4 |=> csr_rdata == '0;
    endproperty
    a_rd_void: assert property (p_rd_void)
        else $error("unknown selector read nonzero");
    property p_st_set;
        cpu_st_valid && cpu_st_dw |=> ext_intr_request_reg
            [$past(cpu_st_pos)][$past(cpu_st_data[37:32])];
    endproperty
    a_st_set: assert property (p_st_set)
        else $error("store did not set pending");
    property p_ien;
        (cpu_intr & ~$past(cpu_psw_ien)) == 4'h0;
    endproperty
    a_ien: assert property (p_ien)
        else $error("interrupt while disabled");
    property p_chip;
        dlv_valid |-> dlv_cpu_id[3:1] == agent_chip_select;
    endproperty
    a_chip: assert property (p_chip)
        else $error("delivery id chip field wrong");
    property p_serial;
        dlv_valid && $past(dlv_valid) |-> dlv_cpu_id != $past(dlv_cpu_id);
    endproperty
    a_serial: assert property (p_serial)
        else $error("same processor written twice");
    // The written processor must see the number pending
    property p_pend;
        dlv_valid && dlv_type == CLID_EXC_INTR |=> ext_intr_request_reg
            [{$past(dlv_cpu_id[4]), $past(dlv_cpu_id[0])}][$past(dlv_num)];
    endproperty
    a_pend: assert property (p_pend)
        else $error("delivery left no pending bit");
    c_dlv: cover property (dlv_valid);
    c_rd: cover property (csr_rvalid);
    c_intr: cover property (cpu_intr[0]);
endmodule
bind clid_core clid_core_assertions u_clid_core_assertions(.clk(clk),
    .rst_n(rst_n), .csr_rd_en(csr_rd_en), .csr_sel(csr_sel),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .cpu_st_valid(cpu_st_valid), .cpu_st_dw(cpu_st_dw),
    .cpu_st_pos(cpu_st_pos), .cpu_st_data(cpu_st_data),
    .cpu_psw_ien(cpu_psw_ien), .cpu_intr(cpu_intr),
    .ext_intr_request_reg(ext_intr_request_reg),
    .agent_chip_select(agent_chip_select), .dlv_valid(dlv_valid),
    .dlv_cpu_id(dlv_cpu_id), .dlv_type(dlv_type), .dlv_num(dlv_num));

// [clid_core_tb.sv]
`timescale 1ns/100ps
module clid_core_tb;
    import clid_pkg::*;
    // Driven inputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] src_on = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [63:0] wdata = 64'h0;
    logic st_v = 1'b0;
    logic st_dw = 1'b0;
    logic [1:0] st_pos = 2'h0;
    logic [63:0] st_data = 64'h0;
    // Observed signals
    logic [7:0] src_irq;
    logic [3:0] ien;
    logic [3:0][63:0] en_mask;
    logic [63:0] rdata;
    logic rvalid;
    logic [3:0] intr;
    logic [3:0][63:0] req;
    logic dlv_v;
    logic [4:0] dlv_id;
    logic [1:0] dlv_ty;
    logic [5:0] dlv_n;
    logic [3:0] exc_v;
    logic [1:0] exc_ty;
    logic found;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Register rows: selector, write data, read back
    logic [2:0] r_sel [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
    logic [63:0] r_wd [5] = '{64'h052a_02c1, 64'h0123_0805_0000_0000,
        '1, 64'h0, '1};
    logic [63:0] r_ex [5] = '{64'h052a_02c1, 64'h0123_0805_0000_0000,
        64'hff00_0000, 64'h0, 64'h0};
    clid_far_model u_clid_far_model(.clk(clk), .src_on(src_on),
        .src_irq(src_irq), .cpu_psw_ien(ien), .ext_intr_enable_mask(en_mask));
    clid_core u_clid_core(.clk(clk), .rst_n(rst_n), .src_irq(src_irq),
        .agent_chip_select(3'h5), .csr_wr_en(wr_en), .csr_rd_en(rd_en),
        .csr_sel(sel), .csr_wdata(wdata), .csr_rdata(rdata),
        .csr_rvalid(rvalid), .cpu_st_valid(st_v), .cpu_st_dw(st_dw),
        .cpu_st_pos(st_pos), .cpu_st_data(st_data), .cpu_clr_valid(1'b0),
        .cpu_clr_pos(2'h0), .cpu_clr_bits(64'h0), .cpu_psw_ien(ien),
        .ext_intr_enable_mask(en_mask), .cpu_intr(intr),
        .ext_intr_request_reg(req), .cpu_exc_valid(exc_v),
        .cpu_exc_type(exc_ty),
        .dlv_valid(dlv_v), .dlv_cpu_id(dlv_id), .dlv_type(dlv_ty),
        .dlv_num(dlv_n));
    always #20 clk = ~clk;
    // Cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [63:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        sel <= s;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Answer stands one cycle, so it is looked at right after its edge
    task automatic rd(input logic [2:0] s, input logic [63:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        sel <= s;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({63'h0, rvalid}, 64'h1);
        chk(rdata, e);
    endtask
    task automatic set_src(input logic [7:0] v);
        @(posedge clk);
        src_on <= v;
    endtask
    task automatic st(input logic [1:0] p, input logic dw,
        input logic [63:0] d);
        @(posedge clk);
        st_v <= 1'b1;
        st_dw <= dw;
        st_pos <= p;
        st_data <= d;
        @(posedge clk);
        st_v <= 1'b0;
    endtask
    // Bounded watch for one delivery pulse
    task automatic wait_dlv;
        found = 1'b0;
        for (int i = 0; i < 40 && !found; i++) begin
            @(posedge clk);
            #1;
            found = (dlv_v === 1'b1);
        end
    endtask
    task automatic dlv(input logic [12:0] e);
        wait_dlv();
        chk({50'h0, found, dlv_id, dlv_ty, dlv_n}, {50'h0, 1'b1, e});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(r_sel[i], r_wd[i]);
            rd(r_sel[i], r_ex[i]);
        end
        // Source 2 reaches positions 0 and 2 in order
        set_src(8'h04);
        dlv({5'h0a, 2'h0, 6'h2a});
        chk({60'h0, exc_v}, 64'h0);
        dlv({5'h1a, 2'h0, 6'h2a});
        chk({62'h0, req[2][42], req[0][42]}, 64'h3);
        repeat (2) @(posedge clk);
        #1;
        chk({60'h0, intr}, 64'h5);
        rd(3'h2, 64'h2000_0000);
        set_src(8'h24);
        repeat (6) @(posedge clk);
        rd(3'h2, 64'h2400_0000);
        // Latched bit survives its source dropping, then clears alone
        set_src(8'h20);
        repeat (6) @(posedge clk);
        wr(3'h2, 64'h2000_0000);
        rd(3'h2, 64'h0400_0000);
        wr(3'h2, 64'h0400_0000);
        dlv({5'h1b, 2'h0, 6'h05});
        rd(3'h2, 64'h0400_0000);
        wr(3'h3, 64'h0);
        set_src(8'h24);
        wait_dlv();
        chk({63'h0, found}, 64'h0);
        wr(3'h4, 64'h1000_0000);
        dlv({5'h0b, 2'h3, 6'h01});
        chk({58'h0, exc_v, exc_ty}, {58'h0, 4'h2, 2'h3});
        wr(3'h4, 64'h4000_0000);
        rd(3'h4, 64'h4000_0000);
        st(2'h1, 1'b1, 64'h0000_0007_0000_0000);
        st(2'h1, 1'b0, 64'h0000_0009_0000_0000);
        repeat (2) @(posedge clk);
        #1;
        chk({62'h0, req[1][9], req[1][7]}, 64'h1);
        chk({63'h0, intr[1]}, 64'h0);
        // Mid-run reset clears flags but keeps the delivery entries
        set_src(8'h00);
        repeat (6) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(3'h2, 64'h0);
        rd(3'h4, 64'h0);
        rd(3'h0, 64'h052a_02c1);
        end_of_test();
    end
endmodule

// [clid_far_model.sv]
`timescale 1ns/100ps
module clid_far_model (
    // Clock
    input wire logic clk,
    // Source levels wanted by the bench, bit i is source i
    input wire logic [7:0] src_on,
    // Source pins and processor interrupt state
    output logic [7:0] src_irq,
    output logic [3:0] cpu_psw_ien,
    output logic [3:0][63:0] ext_intr_enable_mask
);
    initial src_irq = 8'h00;
    // Pins move after an edge, as an unrelated source would
    always @(posedge clk) begin
        src_irq <= src_on;
    end
    // Position 1 keeps interrupts off so the enable gate shows
    assign cpu_psw_ien = 4'hd;
    assign ext_intr_enable_mask = '1;
endmodule

// [clid_pkg.sv]
// Notes on behaviour
// (R01) Request register takes doubleword stores only
// (R02) Write bits 26:31 select pending interrupt 0-63
// (R03) Interrupt needs status enable and mask bit
// (R04) Processor id: slot, agent chip, bus select
// (R05) Position field: slot high bit, bus low
// (R06) Chip zero processors 0, 1, 16, 17
// (R07) Eight sources fixed to status bits 0-7
// (R08) Active source input sets its status bit
// (R09) Write ones clear status; reset clears all
// (R10) Clears touch only chosen bits
// (R11) Clear beats set; held input resets next
// (R12) Mask gates status before sending to chips
// (R13) Force bits raise interrupts past the mask
// (R14) Agent chip receives eight-bit pending source set
// (R15) Check four processor enables per pending source
// (R16) Deliver by writing request register with number
// (R17) Two 64-bit delivery registers, four entries each
// (R18) Entries sit at bits 4:15, 20:31, 36:47, 52:63
// (R19) Exception type picks one of four deliveries
// (R20) Delivery registers read/write; reset keeps them
// (R21) Fixed entry field order and type codes
// (R22) Several enabled processors written one at a time
package clid_pkg;

    // Sizes
    localparam int NSRC = 8;
    localparam int NCPU = 4;
    localparam int DW = 64;
    localparam int SEL_W = 3;

    // Register selectors on the control/status port
    localparam logic [2:0] SEL_DLV_LO = 3'h0;
    localparam logic [2:0] SEL_DLV_HI = 3'h1;
    localparam logic [2:0] SEL_STATUS = 3'h2;
    localparam logic [2:0] SEL_MASK = 3'h3;
    localparam logic [2:0] SEL_FORCE = 3'h4;

    // Source fields sit at big-endian bits 0:7 of a 32-bit word
    localparam int SRC_FLD_LSB = 24;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Interrupt number at big-endian bits 26:31 of a doubleword
    localparam int IRQ_NUM_LSB = 32;
    localparam int IRQ_NUM_W = 6;

    // Delivery entry layout, 12 bits inside each 16-bit slot
    localparam int ENT_W = 12;
    localparam int ENT_SLOT_SH = 4;
    localparam int ENT_EN_LSB = 8;
    localparam int ENT_TYPE_LSB = 6;
    localparam int ENT_NUM_LSB = 0;

    // Exception type codes held in an entry
    typedef enum logic [1:0] {
        CLID_EXC_INTR = 2'h0,
        CLID_EXC_HIGH_PRIORITY_MACHINE_CHECK = 2'h1,
        CLID_EXC_TOC = 2'h2,
        CLID_EXC_PWR = 2'h3
    } clid_exc_e;

    // Big-endian bit i of a source field is source i
    function automatic logic [7:0] clid_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < NSRC; i++) begin
            r[i] = v[NSRC - 1 - i];
        end
        return r;
    endfunction

    // Pick the 12-bit entry of a source from the two registers
    function automatic logic [ENT_W-1:0] clid_entry(
        input logic [DW-1:0] lo,
        input logic [DW-1:0] hi,
        input logic [2:0] src
    );
        logic [DW-1:0] r;
        logic [5:0] sh;
        r = src[2] ? hi : lo;
        sh = {~src[1:0], 4'h0};
        return r[sh +: ENT_W];
    endfunction

    // Five-bit processor id from chip number and position field
    function automatic logic [4:0] clid_cpu_id(
        input logic [2:0] chip,
        input logic [1:0] pos
    );
        // Slot is the high position bit and leads; the bus bit trails
        return {pos[1], chip, pos[0]}; // see R04 see R05 see R06
    endfunction

endpackage

// [clid_util_ctrl.sv]
`timescale 1ns/100ps
module clid_util_ctrl
    import clid_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised source levels, bit i is source i
    input wire logic [7:0] src_lvl,
    // Register writes
    input wire logic wr_en,
    input wire logic [clid_pkg::SEL_W-1:0] wr_sel,
    input wire logic [7:0] wr_bits,
    // Register state and outgoing set
    output logic [7:0] status,
    output logic [7:0] mask,
    output logic [7:0] force_bits,
    output logic [7:0] sent
);
    import clid_pkg::*;

    // All state of the utilities controller
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] force_bits;
    } clid_util_s;

    clid_util_s q;
    clid_util_s d;
    logic [7:0] clr; // Status bits cleared this cycle

    // Next state
    always_comb begin
        d = q;
        clr = (wr_en && wr_sel == SEL_STATUS) ? wr_bits : 8'h00; // see R10
        // Set from level, then clear on top so the clear wins
        d.status = (q.status | src_lvl) & ~clr; // see R08 see R11
        if (wr_en && wr_sel == SEL_MASK) begin
            d.mask = wr_bits;
        end
        if (wr_en && wr_sel == SEL_FORCE) begin
            d.force_bits = wr_bits; // see R13
        end
        if (!rst_n) begin
            d.status = SRC_RST; // see R09
            d.mask = MASK_RST;
            d.force_bits = SRC_RST; // see R13
        end
    end

    // State register
    always_ff @(posedge clk) begin
        q <= d;
    end

    assign status = q.status;
    assign mask = q.mask;
    assign force_bits = q.force_bits;
    // Forced sources bypass the mask, latched ones need it
    assign sent = (q.status & q.mask) | q.force_bits; // see R12 see R13

endmodule
